/* verilog/stm_pkg.sv */
package stm_pkg;
  // register offsets (byte registers on the plain port)
  localparam logic [2:0] STM_ADDR_CTRL0 = 3'h0;
  localparam logic [2:0] STM_ADDR_CTRL1 = 3'h1;
  localparam logic [2:0] STM_ADDR_CNT_LO = 3'h2;
  localparam logic [2:0] STM_ADDR_CNT_HI = 3'h3;
  localparam logic [2:0] STM_ADDR_CMPA_LO = 3'h4;
  localparam logic [2:0] STM_ADDR_CMPA_HI = 3'h5;
  localparam logic [2:0] STM_ADDR_CMPP = 3'h6;
  // control 0 fields
  localparam int STM_C0_PAUSE = 7;
  localparam int STM_C0_CKSEL_LSB = 4;
  localparam int STM_C0_RUN = 3;
  // control 1 fields
  localparam int STM_C1_MODE_LSB = 6;
  localparam int STM_C1_PINF_LSB = 4;
  localparam int STM_C1_OC = 3;
  localparam int STM_C1_POL = 2;
  localparam int STM_C1_DPX = 1;
  localparam int STM_C1_CCLR = 0;
  localparam logic [7:0] STM_C0_RMASK = 8'hF8;
  localparam logic [7:0] STM_RESET_BYTE = 8'h00;
  localparam logic [15:0] STM_CNT_MAX = 16'hFFFF;
  // prescaler divisions
  localparam int STM_DIV_SYS4 = 4;
  localparam int STM_DIV_H16 = 16;
  localparam int STM_DIV_H64 = 64;

  typedef enum logic [1:0] {
    STM_MODE_COMPARE,
    STM_MODE_CAPTURE,
    STM_MODE_PWM,
    STM_MODE_TIMER
  } stm_mode_type;
endpackage

/* verilog/stm_timer.sv */
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////
// How it works
// - 16-bit up-counter advances on each active edge of the chosen clock.
// - comparator P checks counter top byte; comparator A checks all 16 bits.
// - software clears counter only via run rise; overflow or match clears.
// - pause bit holds counter value; clearing it resumes from held value.
// - clock select: sys/4, sys, high/16, high/64, sub, ext rise, ext fall.
// - run low stops and holds counter; run rising edge zeroes it.
// - run rising edge resets output: initial level in compare, inactive level in pwm, active level in single pulse.
// - mode field: compare, capture, pwm or single pulse, timer.
// - compare mode: A match keeps, drives low, drives high or toggles.
// - pwm mode: inactive, active, pwm waveform or single pulse output.
// - capture mode: capture on rising, falling, both edges, or disabled.
// - match requesting the present initial level leaves the output alone.
// - output control sets initial level, pwm active level, pulse level.
// - polarity bit inverts the output pin except in timer mode.
// - duty/period bit swaps comparator P and A roles in pwm.
// - clear select: A match, else P match or overflow when P is zero.
// - counter readable as read-only byte pair; comparator A byte pair rw.
// - control 0 bits two to zero read as zero.
// - low bytes go through a shared buffer moved by high byte access.
// - comparator P zero gives 65536 clocks, else value times 256.
// - separate flags for comparator A match and comparator P match.
module stm_timer
  import stm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic high_clk_tick_i,
  input wire logic sub_clk_tick_i,
  input wire logic ext_clock_pin_i,
  input wire logic capture_pin_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic flag_a_clr_i,
  input wire logic flag_p_clr_i,
  output logic [7:0] rdata_o,
  output logic timer_out_o,
  output logic flag_a_o,
  output logic flag_p_o
);

  logic [7:0] ctrl0_q;
  logic [7:0] ctrl1_q;
  logic [15:0] cnt_q;
  logic [15:0] cmpa_q;
  logic [7:0] cmpp_q;
  logic [7:0] buf_q;
  logic [7:0] rdata_q;
  logic run_prev_q;
  logic out_q;
  logic pulse_done_q;
  logic flag_a_q;
  logic flag_p_q;
  logic [1:0] ck_sync_q;
  logic [1:0] cap_sync_q;
  logic ck_prev_q;
  logic cap_prev_q;
  logic [5:0] div_q;
  logic [5:0] hdiv_q;

  stm_mode_type mode;
  logic [2:0] cksel;
  logic [1:0] pinf;
  logic run_bit;
  logic pause_bit;
  logic run_rise;
  logic tick;
  logic cnt_step;
  logic match_a;
  logic match_p;
  logic overflow;
  logic clear_cnt;
  logic cap_rise;
  logic cap_fall;
  logic cap_evt;
  logic pwm_level;
  logic [16:0] period_v;
  logic [16:0] duty_v;

  assign mode = stm_mode_type'(ctrl1_q[STM_C1_MODE_LSB +: 2]);
  assign cksel = ctrl0_q[STM_C0_CKSEL_LSB +: 3];
  assign pinf = ctrl1_q[STM_C1_PINF_LSB +: 2];
  assign run_bit = ctrl0_q[STM_C0_RUN];
  assign pause_bit = ctrl0_q[STM_C0_PAUSE];
  assign run_rise = run_bit && !run_prev_q;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, first stage feeds only the second
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ck_sync_q <= 2'b00;
      cap_sync_q <= 2'b00;
      ck_prev_q <= 1'b0;
      cap_prev_q <= 1'b0;
    end else begin
      ck_sync_q <= {ck_sync_q[0], ext_clock_pin_i};
      cap_sync_q <= {cap_sync_q[0], capture_pin_i};
      ck_prev_q <= ck_sync_q[1];
      cap_prev_q <= cap_sync_q[1];
    end
  end

  // free-running prescalers; high clock arrives as a one-cycle tick
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= 6'h00;
      hdiv_q <= 6'h00;
    end else begin
      div_q <= div_q + 6'h01;
      if (high_clk_tick_i) begin
        hdiv_q <= hdiv_q + 6'h01;
      end
    end
  end

  // clock source selection, one tick per counter clock
  always_comb begin
    unique case (cksel)
      3'b000: tick = (div_q[1:0] == 2'(STM_DIV_SYS4 - 1));
      3'b001: tick = 1'b1;
      3'b010: tick = high_clk_tick_i &&
                     (hdiv_q[3:0] == 4'(STM_DIV_H16 - 1));
      3'b011: tick = high_clk_tick_i &&
                     (hdiv_q == 6'(STM_DIV_H64 - 1));
      3'b100, 3'b101: tick = sub_clk_tick_i;
      3'b110: tick = ck_sync_q[1] && !ck_prev_q;
      3'b111: tick = !ck_sync_q[1] && ck_prev_q;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // comparators; P fires on its last clock, so P of zero wraps at 65536
  assign cnt_step = run_bit && !pause_bit && tick;
  assign match_a = cnt_step && (cnt_q == cmpa_q);
  assign match_p = cnt_step && (cnt_q[15:8] == cmpp_q - 8'h01) &&
                   (cnt_q[7:0] == 8'hFF);
  assign overflow = cnt_step && (cnt_q == STM_CNT_MAX);

  // period and duty in counter clocks; P zero means 65536
  assign period_v = ctrl1_q[STM_C1_DPX] ? {1'b0, cmpa_q} :
                    {(cmpp_q == 8'h00), cmpp_q, 8'h00};
  assign duty_v = ctrl1_q[STM_C1_DPX] ?
                  {(cmpp_q == 8'h00), cmpp_q, 8'h00} :
                  {1'b0, cmpa_q};

  always_comb begin
    clear_cnt = 1'b0;
    if (mode == STM_MODE_PWM) begin
      clear_cnt = cnt_step &&
                  ({1'b0, cnt_q} + 17'h1 >= period_v);
    end else if (mode != STM_MODE_CAPTURE) begin
      if (ctrl1_q[STM_C1_CCLR]) begin
        clear_cnt = match_a && (cmpa_q != 16'h0000);
      end else begin
        clear_cnt = match_p;
      end
    end
    clear_cnt = clear_cnt || overflow;
  end

  // counter: run edge zeroes, pause and stop hold
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 16'h0000;
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= run_bit;
      if (run_rise) begin
        cnt_q <= 16'h0000;
      end else if (clear_cnt) begin
        cnt_q <= 16'h0000;
      end else if (cnt_step) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // capture edges
  assign cap_rise = cap_sync_q[1] && !cap_prev_q;
  assign cap_fall = !cap_sync_q[1] && cap_prev_q;
  always_comb begin
    unique case (pinf)
      2'b00: cap_evt = cap_rise;
      2'b01: cap_evt = cap_fall;
      2'b10: cap_evt = cap_rise || cap_fall;
      2'b11: cap_evt = 1'b0;
    endcase
    cap_evt = cap_evt && run_bit && (mode == STM_MODE_CAPTURE);
  end

  // interrupt request flags; a set in the clear cycle wins
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_a_q <= 1'b0;
      flag_p_q <= 1'b0;
    end else begin
      if ((match_a && mode != STM_MODE_CAPTURE && cmpa_q != 16'h0000) ||
          cap_evt) begin
        flag_a_q <= 1'b1;
      end else if (flag_a_clr_i) begin
        flag_a_q <= 1'b0;
      end
      if (match_p && !(ctrl1_q[STM_C1_CCLR] && mode != STM_MODE_PWM &&
                       mode != STM_MODE_CAPTURE)) begin
        flag_p_q <= 1'b1;
      end else if (flag_p_clr_i) begin
        flag_p_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output pin logic before polarity
  assign pwm_level = ({1'b0, cnt_q} < duty_v);
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      out_q <= 1'b0;
      pulse_done_q <= 1'b0;
    end else if (run_rise && mode != STM_MODE_CAPTURE &&
                 mode != STM_MODE_TIMER) begin
      // compare mode starts at initial level; pwm modes start inactive, single pulse at active level
      if (mode == STM_MODE_COMPARE) begin
        out_q <= ctrl1_q[STM_C1_OC];
      end else begin
        out_q <= (pinf == 2'b11) ? ctrl1_q[STM_C1_OC] :
                 !ctrl1_q[STM_C1_OC];
      end
      pulse_done_q <= 1'b0;
    end else if (mode == STM_MODE_COMPARE && match_a &&
                 cmpa_q != 16'h0000) begin
      unique case (pinf)
        2'b00: out_q <= out_q;
        2'b01: out_q <= 1'b0;
        2'b10: out_q <= 1'b1;
        2'b11: out_q <= !out_q;
      endcase
    end else if (mode == STM_MODE_PWM) begin
      // pin function must stay fixed while running, see software notes
      unique case (pinf)
        2'b00: out_q <= !ctrl1_q[STM_C1_OC];
        2'b01: out_q <= ctrl1_q[STM_C1_OC];
        2'b10: out_q <= run_bit ? (pwm_level == ctrl1_q[STM_C1_OC]) :
                        out_q;
        2'b11: begin
          // single pulse: one active stretch of duty length then idle
          if (run_bit && !pulse_done_q && clear_cnt) begin
            pulse_done_q <= 1'b1;
          end
          out_q <= (run_bit && !pulse_done_q && pwm_level) ?
                   ctrl1_q[STM_C1_OC] : !ctrl1_q[STM_C1_OC];
        end
      endcase
    end
  end

  // timer mode leaves the pin undefined; held low here
  assign timer_out_o = (mode == STM_MODE_TIMER) ? 1'b0 :
                       (out_q ^ ctrl1_q[STM_C1_POL]);
  assign flag_a_o = flag_a_q;
  assign flag_p_o = flag_p_q;

  //////////////////////////////////////////////////////////////////////////////
  // register port; mode changes are expected only while stopped
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl0_q <= STM_RESET_BYTE;
      ctrl1_q <= STM_RESET_BYTE;
      cmpp_q <= STM_RESET_BYTE;
    end else if (wr_i) begin
      unique case (addr_i)
        STM_ADDR_CTRL0: ctrl0_q <= wdata_i & STM_C0_RMASK;
        STM_ADDR_CTRL1: ctrl1_q <= wdata_i;
        STM_ADDR_CMPP: cmpp_q <= wdata_i;
        default: ;
      endcase
    end
  end

  // comparator A pair, shared low byte buffer, capture load
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cmpa_q <= 16'h0000;
      buf_q <= STM_RESET_BYTE;
    end else begin
      if (cap_evt) begin
        cmpa_q <= cnt_q;
      end else if (wr_i && addr_i == STM_ADDR_CMPA_HI) begin
        cmpa_q <= {wdata_i, buf_q};
      end
      if (wr_i && addr_i == STM_ADDR_CMPA_LO) begin
        buf_q <= wdata_i;
      end else if (rd_i && addr_i == STM_ADDR_CNT_HI) begin
        buf_q <= cnt_q[7:0];
      end else if (rd_i && addr_i == STM_ADDR_CMPA_HI) begin
        buf_q <= cmpa_q[7:0];
      end
    end
  end

  // read data one cycle after the strobe; low bytes come from the buffer
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= STM_RESET_BYTE;
    end else if (rd_i) begin
      unique case (addr_i)
        STM_ADDR_CTRL0: rdata_q <= ctrl0_q & STM_C0_RMASK;
        STM_ADDR_CTRL1: rdata_q <= ctrl1_q;
        STM_ADDR_CNT_LO: rdata_q <= buf_q;
        STM_ADDR_CNT_HI: rdata_q <= cnt_q[15:8];
        STM_ADDR_CMPA_LO: rdata_q <= buf_q;
        STM_ADDR_CMPA_HI: rdata_q <= cmpa_q[15:8];
        STM_ADDR_CMPP: rdata_q <= cmpp_q;
        default: rdata_q <= STM_RESET_BYTE;
      endcase
    end else begin
      rdata_q <= STM_RESET_BYTE;
    end
  end
  assign rdata_o = rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_run_rise_zero;
    @(posedge mclk_i) disable iff (rst_i)
    run_rise |=> (cnt_q == 16'h0000);
  endproperty
  a_run_rise_zero: assert property (p_run_rise_zero)
    else $error("counter not zeroed on run rise");
  property p_stop_hold;
    @(posedge mclk_i) disable iff (rst_i)
    (!run_bit && run_prev_q == run_bit) |=> $stable(cnt_q);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("counter moved while stopped");
  property p_pause_hold;
    @(posedge mclk_i) disable iff (rst_i)
    (pause_bit && !run_rise) |=> $stable(cnt_q);
  endproperty
  a_pause_hold: assert property (p_pause_hold)
    else $error("counter moved while paused");
  property p_sys_count;
    @(posedge mclk_i) disable iff (rst_i)
    (cnt_step && !clear_cnt && !run_rise && cksel == 3'b001)
      |=> (cnt_q == $past(cnt_q) + 16'h0001);
  endproperty
  a_sys_count: assert property (p_sys_count)
    else $error("counter failed to advance");
  property p_ctrl0_low;
    @(posedge mclk_i) disable iff (rst_i)
    ctrl0_q[2:0] == 3'b000;
  endproperty
  a_ctrl0_low: assert property (p_ctrl0_low)
    else $error("unimplemented control bits set");
  property p_flag_a_set;
    @(posedge mclk_i) disable iff (rst_i)
    cap_evt |=> flag_a_q && (cmpa_q == $past(cnt_q));
  endproperty
  a_flag_a_set: assert property (p_flag_a_set)
    else $error("capture did not load comparator A");
  sequence s_lo_write;
    wr_i && addr_i == STM_ADDR_CMPA_LO;
  endsequence
  sequence s_hi_write;
    wr_i && addr_i == STM_ADDR_CMPA_HI && !cap_evt;
  endsequence
  property p_pair_write;
    @(posedge mclk_i) disable iff (rst_i)
    s_lo_write ##1 s_hi_write |=>
      (cmpa_q[7:0] == $past(wdata_i, 2)) &&
      (cmpa_q[15:8] == $past(wdata_i));
  endproperty
  a_pair_write: assert property (p_pair_write)
    else $error("comparator A pair write mismatch");
  property p_cclr_a;
    @(posedge mclk_i) disable iff (rst_i)
    (mode == STM_MODE_COMPARE && ctrl1_q[STM_C1_CCLR] && match_a &&
     cmpa_q != 16'h0000 && !run_rise) |=> (cnt_q == 16'h0000);
  endproperty
  a_cclr_a: assert property (p_cclr_a)
    else $error("A match did not clear counter");
  property p_polarity;
    @(posedge mclk_i) disable iff (rst_i)
    (mode != STM_MODE_TIMER) |->
      (timer_out_o == (out_q ^ ctrl1_q[STM_C1_POL]));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("output polarity wrong");

endmodule

/* test/stm_pin_model.sv */
`timescale 1ns/1ns
// tick sources plus an external clock pin that idles low when not in use
module stm_pin_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ext_run_i,
  output logic high_tick_o,
  output logic sub_tick_o,
  output logic ext_clk_o
);
  logic [3:0] div_q;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= 4'h0;
      ext_clk_o <= 1'b0;
    end else begin
      div_q <= (div_q == 4'h4) ? 4'h0 : div_q + 4'h1;
      if (div_q == 4'h4) begin
        ext_clk_o <= ext_run_i & ~ext_clk_o;
      end
    end
  end
  assign high_tick_o = ~rst_i;
  assign sub_tick_o = (div_q == 4'h0) & ~rst_i;
endmodule

/* test/tb.sv */
`timescale 1ns/1ns
module tb
  import stm_pkg::*;
;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ext_run = 1'b0;
  logic cap = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic clr_a = 1'b0;
  logic clr_p = 1'b0;
  logic high_tick, sub_tick, ext_clk, tout, flag_a, flag_p;
  logic [7:0] rdata;
  int fails = 0;
  int checks_done = 0;

  always #5 mclk_i = ~mclk_i;

  stm_pin_model u_stm_pin_model (.mclk_i(mclk_i), .rst_i(rst_i),
    .ext_run_i(ext_run), .high_tick_o(high_tick), .sub_tick_o(sub_tick),
    .ext_clk_o(ext_clk));
  stm_timer u_stm_timer (.mclk_i(mclk_i), .rst_i(rst_i),
    .high_clk_tick_i(high_tick), .sub_clk_tick_i(sub_tick),
    .ext_clock_pin_i(ext_clk), .capture_pin_i(cap), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .flag_a_clr_i(clr_a),
    .flag_p_clr_i(clr_p), .rdata_o(rdata), .timer_out_o(tout),
    .flag_a_o(flag_a), .flag_p_o(flag_p));

  //////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] lo,
                     input logic [15:0] hi, input logic [15:0] g);
    checks_done++;
    if (((g >= lo) && (g <= hi)) !== 1'b1) begin
      fails++;
      $display("unexpected %s expected %0h..%0h seen %0h", n, lo, hi, g);
    end
  endtask

  task automatic chkb(input string n, input logic e, input logic g);
    chk(n, {15'h0, e}, {15'h0, e}, {15'h0, g});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic wr8(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
    #1;
  endtask

  // low byte into the buffer, then the high byte, back to back
  task automatic wr_pair(input logic [2:0] hi, input logic [15:0] d);
    @(posedge mclk_i);
    addr <= hi - 3'h1;
    wdata <= d[7:0];
    wr <= 1'b1;
    @(posedge mclk_i);
    addr <= hi;
    wdata <= d[15:8];
    @(posedge mclk_i);
    wr <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd8(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // high byte first, so the low byte comes from the shared buffer
  task automatic rd16(input logic [2:0] hi, output logic [15:0] v);
    rd8(hi, v[15:8]);
    rd8(hi - 3'h1, v[7:0]);
  endtask

  // stop first so that the run bit really rises
  task automatic run_on(input logic [2:0] s);
    wr8(STM_ADDR_CTRL0, {1'b0, s, 4'h0});
    wr8(STM_ADDR_CTRL0, {1'b0, s, 4'h8});
  endtask

  task automatic run_off(input logic [2:0] s);
    wr8(STM_ADDR_CTRL0, {1'b0, s, 4'h0});
  endtask

  task automatic clr();
    @(posedge mclk_i);
    clr_a <= 1'b1;
    clr_p <= 1'b1;
    @(posedge mclk_i);
    clr_a <= 1'b0;
    clr_p <= 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] b;
    logic [15:0] v;
    for (int i = 0; i < 8; i++) begin
      rd8(3'(i), b);
      chk("reset byte", 16'h0000, 16'h0000, {8'h00, b});
    end
    wr8(STM_ADDR_CTRL0, 8'h87);
    rd8(STM_ADDR_CTRL0, b);
    chk("ctrl0", 16'h0080, 16'h0080, {8'h00, b});
    wr8(STM_ADDR_CTRL0, 8'h00);
    wr8(STM_ADDR_CNT_LO, 8'h55);
    wr8(STM_ADDR_CNT_HI, 8'h66);
    rd16(STM_ADDR_CNT_HI, v);
    chk("count", 16'h0000, 16'h0000, v);
    wr8(STM_ADDR_CMPA_LO, 8'h34);
    rd16(STM_ADDR_CMPA_HI, v);
    chk("cmp a", 16'h0000, 16'h0000, v);
    wr8(STM_ADDR_CMPA_HI, 8'h12);
    rd16(STM_ADDR_CMPA_HI, v);
    // the high byte read above refilled the buffer with the old low byte
    chk("cmp a", 16'h1200, 16'h1200, v);
    wr_pair(STM_ADDR_CMPA_HI, 16'h1234);
    rd16(STM_ADDR_CMPA_HI, v);
    chk("cmp a pair", 16'h1234, 16'h1234, v);
    wr8(STM_ADDR_CMPP, 8'hA5);
    rd8(STM_ADDR_CMPP, b);
    chk("cmp p", 16'h00A5, 16'h00A5, {8'h00, b});
  endtask

  // about 162 cycles of run per clock source
  task automatic t_clock();
    int ev[8] = '{40, 162, 10, 2, 32, 32, 16, 16};
    logic [15:0] v;
    logic [15:0] lo;
    for (int s = 0; s < 8; s++) begin
      run_on(3'(s));
      repeat (160) @(posedge mclk_i);
      run_off(3'(s));
      rd16(STM_ADDR_CNT_HI, v);
      lo = (ev[s] > 4) ? 16'(ev[s] - 4) : 16'h0000;
      chk("clock count", lo, 16'(ev[s] + 4), v);
    end
  endtask

  task automatic t_pause();
    logic [15:0] v1, v2, v;
    run_on(3'h1);
    tick(10);
    wr8(STM_ADDR_CTRL0, 8'h98);
    rd16(STM_ADDR_CNT_HI, v1);
    tick(20);
    rd16(STM_ADDR_CNT_HI, v2);
    chk("paused count", v1, v1, v2);
    wr8(STM_ADDR_CTRL0, 8'h18);
    tick(10);
    run_off(3'h1);
    rd16(STM_ADDR_CNT_HI, v);
    chk("resumed count", v1 + 16'd10, v1 + 16'd16, v);
    tick(10);
    rd16(STM_ADDR_CNT_HI, v2);
    chk("stopped count", v, v, v2);
    run_on(3'h1);
    run_off(3'h1);
    rd16(STM_ADDR_CNT_HI, v);
    chk("restart count", 16'h0000, 16'h0004, v);
  endtask

  // compare match at 20 clears the count; stop before the second match
  task automatic t_compare();
    logic [1:0] pf;
    logic oc, pol, e;
    logic [15:0] v;
    wr_pair(STM_ADDR_CMPA_HI, 16'h0014);
    clr();
    for (int i = 0; i < 16; i++) begin
      {pf, oc, pol} = 4'(i);
      wr8(STM_ADDR_CTRL1, {2'b00, pf, oc, pol, 2'b01});
      run_on(3'h1);
      tick(3);
      chkb("pin initial", oc ^ pol, tout);
      tick(25);
      run_off(3'h1);
      e = (pf == 2'h0) ? oc : (pf == 2'h3) ? ~oc : pf[1];
      chkb("pin after match", e ^ pol, tout);
      chkb("flag a", 1'b1, flag_a);
      chkb("flag p", 1'b0, flag_p);
      rd16(STM_ADDR_CNT_HI, v);
      chk("count", 16'h0000, 16'h0014, v);
      clr();
      tick(1);
      chkb("flag a cleared", 1'b0, flag_a);
    end
    wr8(STM_ADDR_CTRL1, 8'hCD);
    run_on(3'h1);
    tick(30);
    chkb("timer mode pin", 1'b0, tout);
    run_off(3'h1);
  endtask

  task automatic t_p();
    logic [15:0] v;
    wr_pair(STM_ADDR_CMPA_HI, 16'h0000);
    wr8(STM_ADDR_CMPP, 8'h01);
    wr8(STM_ADDR_CTRL1, 8'h00);
    clr();
    run_on(3'h1);
    // P of one clears after 256 clocks, so 145 more steps follow
    tick(400);
    run_off(3'h1);
    rd16(STM_ADDR_CNT_HI, v);
    chk("count after p match", 16'd140, 16'd150, v);
    chkb("flag p", 1'b1, flag_p);
    chkb("flag a", 1'b0, flag_a);
    clr();
  endtask

  // the timer is stopped before every control change
  task automatic t_pwm();
    logic [7:0] cv[4] = '{8'h88, 8'h98, 8'h9C, 8'h8C};
    logic ev[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    // quarter duty, half duty with swapped roles, then one single pulse
    logic [15:0] av[3] = '{16'h0040, 16'h0200, 16'h0040};
    logic [7:0] c1[3] = '{8'hA8, 8'hAA, 8'hB8};
    int hv[3] = '{128, 256, 60};
    int n;
    for (int k = 0; k < 3; k++) begin
      wr_pair(STM_ADDR_CMPA_HI, av[k]);
      wr8(STM_ADDR_CTRL1, c1[k]);
      run_on(3'h1);
      tick(4);
      n = 0;
      repeat (512) begin
        tick(1);
        n += (tout === 1'b1) ? 1 : 0;
      end
      run_off(3'h1);
      chk("pwm high", 16'(hv[k] - 4), 16'(hv[k] + 4), 16'(n));
    end
    chkb("pwm flag p", 1'b1, flag_p);
    for (int i = 0; i < 4; i++) begin
      wr8(STM_ADDR_CTRL1, cv[i]);
      run_on(3'h1);
      tick(5);
      chkb("pwm fixed level", ev[i], tout);
      run_off(3'h1);
    end
  endtask

  task automatic t_capture();
    logic [15:0] v;
    for (int i = 0; i < 4; i++) begin
      wr_pair(STM_ADDR_CMPA_HI, 16'h0000);
      wr8(STM_ADDR_CTRL1, {2'b01, 2'(i), 4'h0});
      run_on(3'h1);
      clr();
      @(posedge mclk_i);
      cap <= 1'b1;
      tick(8);
      chkb("capture rise", i == 0 || i == 2, flag_a);
      clr();
      @(posedge mclk_i);
      cap <= 1'b0;
      tick(8);
      chkb("capture fall", i == 1 || i == 2, flag_a);
      run_off(3'h1);
      rd16(STM_ADDR_CMPA_HI, v);
      chkb("captured value", i != 3, v != 16'h0000);
      clr();
    end
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    ext_run <= 1'b1;
    t_regs();
    t_clock();
    t_pause();
    t_compare();
    t_p();
    t_pwm();
    t_capture();
    complete_run();
  end

  // the whole sequence needs well under ten thousand cycles
  initial begin
    repeat (30000) @(posedge mclk_i);
    fails++;
    complete_run();
  end
endmodule
